/* File: ssb_pkg.sv */
// Shared constants and types of the synchronous serial channel and its peer.
// Assumes a single 40 MHz module clock on both ends.
`default_nettype none
package ssb_pkg;
  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int          WORD_W     = 16;
  localparam int          MOD_CLK_HZ = 40_000_000;
  localparam int          SYNC_LEN   = 6;              // Pin sync plus history
  // ****************************************************************
  // Register indices on the software port
  // ****************************************************************
  localparam logic [1:0]  REG_CTRL   = 2'h0;
  localparam logic [1:0]  REG_STAT   = 2'h1;
  localparam logic [1:0]  REG_BRT    = 2'h2;
  localparam logic [1:0]  REG_BUF    = 2'h3;           // Write tx, read rx
  // ****************************************************************
  // Control bit positions and reset value
  // ****************************************************************
  localparam int          CB_EN      = 0;
  localparam int          CB_MASTER  = 1;
  localparam int          CB_DRIVE   = 2;
  localparam int          CB_ODRAIN  = 3;
  localparam int          CB_AREINIT = 4;
  localparam int          CB_IEN_LO  = 5;              // Four enables, flag order
  localparam int          CB_WID_LO  = 12;             // Width minus one, 4 bits
  localparam logic [15:0] CTRL_RST   = 16'hF000;
  localparam logic [15:0] BRT_RST    = 16'h0000;
  // ****************************************************************
  // Status bit positions
  // ****************************************************************
  localparam int          SB_TXU     = 0;
  localparam int          SB_RXO     = 1;
  localparam int          SB_PHS     = 2;
  localparam int          SB_BRT     = 3;
  localparam int          SB_BUSY    = 4;
  localparam int          SB_TXE     = 5;
  localparam int          SB_RXF     = 6;
  localparam int          SB_ECHO    = 7;
  localparam int          NFLAG      = 4;
  // ****************************************************************
  // Frame engine states
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_RUN} ssb_state_t;
endpackage
`default_nettype wire

/* File: ssb_link_if.sv */
// Link between channel and peer: one shift clock line and one shared data line.
// Data line is wired-AND with pull-up; clock idles low when nobody drives it.
`timescale 1ns/10ps
`default_nettype none
interface ssb_link_if;
  logic dev_clk_o;
  logic dev_clk_oe;
  logic dev_dat_o;
  logic dev_dat_oe;
  logic peer_clk_o;
  logic peer_clk_oe;
  logic peer_dat_o;
  logic peer_dat_oe;
  logic clk_line;
  logic dat_line;
  // ****************************************************************
  // Line resolution
  // ****************************************************************
  // Clock from the device when it drives it, otherwise from the peer
  assign clk_line = dev_clk_oe ? dev_clk_o : (peer_clk_oe & peer_clk_o);
  // Undriven data line floats high
  assign dat_line = (~dev_dat_oe | dev_dat_o) & (~peer_dat_oe | peer_dat_o);
  modport dev  (output dev_clk_o, dev_clk_oe, dev_dat_o, dev_dat_oe,
                input clk_line, dat_line);
  modport peer (output peer_clk_o, peer_clk_oe, peer_dat_o, peer_dat_oe,
                input clk_line, dat_line);
endinterface
`default_nettype wire

/* File: ssb_channel.sv */
// Synchronous serial channel: half-duplex shifter, bitrate generator, faults.
// Assumes software port in the CLK domain; link lines arrive asynchronously.
// Function
// RULE_01: Sender reads own bits back from line
// RULE_02: Drive only when sending, or open-drain ones
// RULE_03: Flag transmit buffer empty for next word
// RULE_04: Refilled buffer continues frame without gap
// RULE_05: Long frames are multiples of word width
// RULE_06: Own 16-bit bitrate counter with reload
// RULE_07: Counter runs on module clock, downward
// RULE_08: Disabled: bitrate register stores and returns reload
// RULE_09: Enabled: bitrate register reads live timer
// RULE_10: Software never writes bitrate while enabled
// RULE_11: Enable loads timer and starts counting
// RULE_12: Shift clock is module clock over 2(reload+1)
// RULE_13: Reload zero only for master; slave needs one
// RULE_14: Four faults; underrun and bitrate slave only
// RULE_15: Fault sets flag, enabled fault raises line
// RULE_16: Fault flags stay until software clears
// RULE_17: Overrun flags and overwrites receive buffer
// RULE_18: Phase fault on data change near latch
// RULE_19: Slave flags clock beyond double or half
// RULE_20: Bitrate fault with auto-reinit resets channel
// RULE_21: Stale buffer: underrun, shift old contents
// RULE_22: Idle slaves load all ones before transfers; code keeps the old shift contents
// RULE_23: Master first bit on tick, slave immediately
// RULE_24: Each underflow reloads and toggles shift clock
`timescale 1ns/10ps
`default_nettype none
module ssb_channel (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic [1:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  output logic             TX_IRQ,
  output logic             RX_IRQ,
  output logic             ERR_IRQ,
  ssb_link_if.dev          LNK
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [15:0]               ctrl;
  logic [15:0]               reload;
  logic [15:0]               brt;
  logic [15:0]               tb;
  logic [15:0]               rb;
  logic [15:0]               sh;
  logic [15:0]               txw;
  logic [4:0]                bitcnt;
  logic [17:0]               gap;
  logic [ssb_pkg::SYNC_LEN-1:0] ck_s;
  logic [ssb_pkg::SYNC_LEN-1:0] dt_s;
  logic [1:0]                lat_h;
  logic [ssb_pkg::NFLAG-1:0] flags;
  logic [ssb_pkg::NFLAG-1:0] ev;
  ssb_pkg::ssb_state_t       st;
  logic                      msclk;
  logic                      rxb;
  logic                      tb_full;
  logic                      fresh;
  logic                      rb_full;
  logic                      done;
  logic                      under;
  logic                      echo_bad;
  logic                      en;
  logic                      mst;
  logic                      tick;
  logic                      lat;
  logic                      sft;
  logic                      s_rise;
  logic                      s_fall;
  logic                      reinit;
  logic [4:0]                wid;
  logic [16:0]               expv;
  logic [15:0]               wmask;
  logic [15:0]               rxw;
  assign en     = ctrl[ssb_pkg::CB_EN];
  assign mst    = ctrl[ssb_pkg::CB_MASTER];
  assign wid    = {1'b0, ctrl[ssb_pkg::CB_WID_LO +: 4]} + 5'h01;
  assign wmask  = 16'hFFFF >> (5'h10 - wid);
  assign rxw    = {sh[14:0], rxb};
  assign expv   = {1'b0, reload} + 17'h00001;
  // ****************************************************************
  // Link input synchronisers
  // ****************************************************************
  // RULE_01: own bits read back
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ck_s <= '0;
      dt_s <= '1;
    end else begin
      ck_s <= {ck_s[ssb_pkg::SYNC_LEN-2:0], LNK.clk_line};
      dt_s <= {dt_s[ssb_pkg::SYNC_LEN-2:0], LNK.dat_line};
    end
  end
  assign s_rise = ck_s[1] & ~ck_s[2];
  assign s_fall = ~ck_s[1] & ck_s[2];
  // ****************************************************************
  // Bitrate generator
  // ****************************************************************
  // RULE_06: 16-bit down counter
  // RULE_07: counts on CLK
  // RULE_11: held at reload while disabled
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      brt <= ssb_pkg::BRT_RST;
    end else if (!en || brt == 16'h0000) begin
      brt <= reload;
    end else begin
      brt <= brt - 16'h0001;
    end
  end
  assign tick = en & (brt == 16'h0000);
  // Shift events; RULE_12 and RULE_24: two underflows per clock period
  assign lat  = mst ? (tick & (st == ssb_pkg::ST_RUN) & ~msclk) : s_rise;
  assign sft  = mst ? (tick & (st == ssb_pkg::ST_RUN) & msclk) : s_fall;
  // ****************************************************************
  // Software registers
  // ****************************************************************
  // Control and reload writes
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl   <= ssb_pkg::CTRL_RST;
      reload <= ssb_pkg::BRT_RST;
    end else if (WR) begin
      if (ADDR == ssb_pkg::REG_CTRL) begin
        ctrl[11:0] <= WDATA[11:0];
        // RULE_05: width fixed while enabled
        if (!en) begin
          ctrl[15:12] <= WDATA[15:12];
        end
      end
      // RULE_08: reload store
      // RULE_10: writes while enabled ignored
      if (ADDR == ssb_pkg::REG_BRT && !en) begin
        reload <= WDATA;
      end
    end
  end
  // Read data, one cycle after the strobe
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      case (ADDR)
        ssb_pkg::REG_CTRL: RDATA <= ctrl;
        ssb_pkg::REG_STAT: RDATA <= {8'h00, echo_bad, rb_full, ~tb_full,
                                     (st != ssb_pkg::ST_IDLE), flags};
        // RULE_08: reload when disabled
        // RULE_09: live timer when enabled
        ssb_pkg::REG_BRT:  RDATA <= en ? brt : reload;
        default:           RDATA <= rb;
      endcase
    end
  end
  // ****************************************************************
  // Frame engine
  // ****************************************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st      <= ssb_pkg::ST_IDLE;
      sh      <= 16'h0000;
      txw     <= 16'h0000;
      tb      <= 16'h0000;
      rb      <= 16'h0000;
      bitcnt  <= 5'h00;
      msclk   <= 1'b0;
      rxb     <= 1'b0;
      tb_full <= 1'b0;
      fresh   <= 1'b0;
      done    <= 1'b0;
      under   <= 1'b0;
      TX_IRQ  <= 1'b0;
    end else begin
      done   <= 1'b0;
      under  <= 1'b0;
      TX_IRQ <= 1'b0;
      if (!en || reinit) begin
        // RULE_20: auto reset on bitrate fault
        st     <= ssb_pkg::ST_IDLE;
        bitcnt <= 5'h00;
        msclk  <= 1'b0;
        fresh  <= 1'b0;              // No word loaded since restart
      end else begin
        case (st)
          ssb_pkg::ST_IDLE: begin
            if (mst) begin
              if (tb_full) begin
                st <= ssb_pkg::ST_LEAD;
              end
            end else if (s_rise) begin
              // RULE_21: stale buffer, old shift contents go out
              under  <= ~fresh;
              fresh  <= 1'b0;
              rxb    <= dt_s[1];
              bitcnt <= 5'h01;
              st     <= ssb_pkg::ST_RUN;
            end else if (tb_full) begin
              // RULE_23: slave first bit at once
              sh      <= tb << (5'h10 - wid);
              txw     <= tb;
              tb_full <= 1'b0;
              fresh   <= 1'b1;
              TX_IRQ  <= 1'b1;
            end
          end
          ssb_pkg::ST_LEAD: begin
            // RULE_23: master first bit on next tick
            if (tick) begin
              sh      <= tb << (5'h10 - wid);
              txw     <= tb;
              tb_full <= 1'b0;
              TX_IRQ  <= 1'b1;
              st      <= ssb_pkg::ST_RUN;
            end
          end
          ssb_pkg::ST_RUN: begin
            if (lat) begin
              rxb    <= dt_s[1];
              msclk  <= mst;
              bitcnt <= bitcnt + 5'h01;
            end
            if (sft) begin
              msclk <= 1'b0;
              if (bitcnt == wid) begin
                // RULE_17: receive buffer overwritten
                rb     <= rxw;
                done   <= 1'b1;
                bitcnt <= 5'h00;
                if (tb_full) begin
                  // RULE_04: back-to-back, no gap
                  // RULE_03: buffer empty again
                  sh      <= tb << (5'h10 - wid);
                  txw     <= tb;
                  tb_full <= 1'b0;
                  fresh   <= 1'b1;
                  TX_IRQ  <= 1'b1;
                end
                if (!(mst && tb_full)) begin
                  st <= ssb_pkg::ST_IDLE;
                end
              end else begin
                sh <= rxw;
              end
            end
          end
          default: st <= ssb_pkg::ST_IDLE;
        endcase
      end
      // New word pending; a same-cycle write stays pending
      if (WR && ADDR == ssb_pkg::REG_BUF) begin
        tb      <= WDATA;
        tb_full <= 1'b1;
      end
    end
  end
  assign RX_IRQ = done;
  // ****************************************************************
  // Fault detection
  // ****************************************************************
  // Latch history and slave edge spacing
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lat_h <= 2'b00;
      gap   <= 18'h00000;
    end else begin
      lat_h <= {lat_h[0], lat & (st == ssb_pkg::ST_RUN || !mst)};
      if (s_rise || s_fall || st != ssb_pkg::ST_RUN) begin
        gap <= 18'h00001;
      end else if (gap != 18'h3FFFF) begin
        gap <= gap + 18'h00001;
      end
    end
  end
  // RULE_14: underrun and bitrate fault only as slave
  assign ev[ssb_pkg::SB_TXU] = under & ~mst;
  // RULE_17: new frame before old one read
  assign ev[ssb_pkg::SB_RXO] = done & rb_full;
  // RULE_18: change from two before to two after latch
  assign ev[ssb_pkg::SB_PHS] = lat_h[1] & (|(dt_s[4:1] ^ dt_s[5:2]));
  // RULE_19: edge spacing off by more than factor two
  // RULE_13: slave expects reload of one or more
  assign ev[ssb_pkg::SB_BRT] = en & ~mst & (st == ssb_pkg::ST_RUN) &
                               (((s_rise | s_fall) & ({1'b0, gap} < {2'b00, expv[16:1]}))
                               | (gap > {expv, 1'b0}));
  assign reinit = ev[ssb_pkg::SB_BRT] & ctrl[ssb_pkg::CB_AREINIT];
  // Sticky flags, write one to clear, set wins
  // RULE_16: held until software clears
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flags    <= '0;
      rb_full  <= 1'b0;
      echo_bad <= 1'b0;
    end else begin
      flags <= ev | (flags & ~((WR && ADDR == ssb_pkg::REG_STAT) ?
                               WDATA[ssb_pkg::NFLAG-1:0] : 4'h0));
      if (done) begin
        rb_full <= 1'b1;
      end else if (RD && ADDR == ssb_pkg::REG_BUF) begin
        rb_full <= 1'b0;
      end
      // RULE_01: echo compare of received word with txw, the next word after a back-to-back refill
      if (done && ctrl[ssb_pkg::CB_DRIVE]) begin
        echo_bad <= |((rb ^ txw) & wmask);
      end
    end
  end
  // RULE_15: enabled flags onto the fault line
  assign ERR_IRQ = |(flags & ctrl[ssb_pkg::CB_IEN_LO +: ssb_pkg::NFLAG]);
  // ****************************************************************
  // Link outputs
  // ****************************************************************
  // RULE_02: drive when sending, or pull low only
  assign LNK.dev_dat_o  = sh[15];
  assign LNK.dev_dat_oe = en & ctrl[ssb_pkg::CB_DRIVE] &
                          (~ctrl[ssb_pkg::CB_ODRAIN] | ~sh[15]);
  assign LNK.dev_clk_o  = msclk;
  assign LNK.dev_clk_oe = en & mst;
endmodule
`default_nettype wire

/* File: ssb_peer.sv */
// Far end of the link: a shift clock master with its own bitrate divider.
// Assumes user controls in the CLK domain; line inputs are asynchronous.
`timescale 1ns/10ps
`default_nettype none
module ssb_peer (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic [15:0] RELOAD,
  input  wire logic [4:0]  WIDTH,
  input  wire logic        START,
  input  wire logic [15:0] TX_DATA,
  input  wire logic        DRIVE,
  input  wire logic        OPEN_DRAIN,
  output logic             BUSY,
  output logic             DONE,
  output logic      [15:0] RX_DATA,
  ssb_link_if.peer         LNK
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [15:0]         cnt;
  logic [15:0]         sh;
  logic [15:0]         pdata;
  logic [4:0]          wid;
  logic [4:0]          bitcnt;
  logic [1:0]          dt_s;
  logic                pend;
  logic                pclk;
  logic                tick;
  ssb_pkg::ssb_state_t st;
  // Line data synchroniser
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dt_s <= 2'b11;
    end else begin
      dt_s <= {dt_s[0], LNK.dat_line};
    end
  end
  // Divider; RULE_13 and RULE_19: same reload as the slave, one or more
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt <= ssb_pkg::BRT_RST;
    end else if (cnt == 16'h0000) begin
      cnt <= RELOAD;
    end else begin
      cnt <= cnt - 16'h0001;
    end
  end
  assign tick = (cnt == 16'h0000);
  // ****************************************************************
  // Frame engine
  // ****************************************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st      <= ssb_pkg::ST_IDLE;
      sh      <= 16'hFFFF;
      pdata   <= 16'h0000;
      wid     <= 5'h10;
      bitcnt  <= 5'h00;
      pend    <= 1'b0;
      pclk    <= 1'b0;
      DONE    <= 1'b0;
      RX_DATA <= 16'h0000;
    end else begin
      DONE <= 1'b0;
      case (st)
        ssb_pkg::ST_IDLE: begin
          if (pend) begin
            // RULE_05: width taken only between frames
            wid <= WIDTH;
            st  <= ssb_pkg::ST_LEAD;
          end
        end
        ssb_pkg::ST_LEAD: begin
          if (tick) begin
            sh   <= pdata << (5'h10 - wid);
            pend <= 1'b0;
            st   <= ssb_pkg::ST_RUN;
          end
        end
        ssb_pkg::ST_RUN: begin
          if (tick && !pclk) begin
            pclk   <= 1'b1;
            bitcnt <= bitcnt + 5'h01;
          end else if (tick) begin
            // Sample at end of high phase: a slave answer crosses two syncs each way
            pclk <= 1'b0;
            if (bitcnt == wid) begin
              RX_DATA <= {sh[14:0], dt_s[1]};
              DONE    <= 1'b1;
              bitcnt  <= 5'h00;
              if (pend) begin
                sh   <= pdata << (5'h10 - wid);
                pend <= 1'b0;
              end else begin
                st <= ssb_pkg::ST_IDLE;
              end
            end else begin
              sh <= {sh[14:0], dt_s[1]};
            end
          end
        end
        default: st <= ssb_pkg::ST_IDLE;
      endcase
      if (START) begin
        pdata <= TX_DATA;
        pend  <= 1'b1;
      end
    end
  end
  assign BUSY            = (st != ssb_pkg::ST_IDLE) | pend;
  // Drive only while sending, or pull low only
  assign LNK.peer_dat_o  = sh[15];
  assign LNK.peer_dat_oe = DRIVE & (~OPEN_DRAIN | ~sh[15]);
  assign LNK.peer_clk_o  = pclk;
  assign LNK.peer_clk_oe = 1'b1;
endmodule
`default_nettype wire

/* File: ssb_link_checker.sv */
// Checker of the link lines between channel and peer.
// Assumes both ends run with a reload of 3, so one shift clock phase is 4 CLK cycles.
`timescale 1ns/10ps
`default_nettype none
module ssb_link_checker (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic dev_clk_o,
  input wire logic dev_clk_oe,
  input wire logic dev_dat_o,
  input wire logic dev_dat_oe,
  input wire logic peer_clk_o,
  input wire logic peer_clk_oe,
  input wire logic peer_dat_o,
  input wire logic peer_dat_oe,
  input wire logic clk_line,
  input wire logic dat_line
);
  // ****************************************************************
  // Line assertions
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  a_dev_high_len: assert property ($rose(dev_clk_o) && dev_clk_oe |-> dev_clk_o[*4] ##1 !dev_clk_o)
    else $error("device clock high phase wrong");
  a_dev_low_len: assert property ($fell(dev_clk_o) && dev_clk_oe |-> !dev_clk_o[*4])
    else $error("device clock low phase short");
  a_peer_high_len: assert property ($rose(peer_clk_o) |-> peer_clk_o[*4] ##1 !peer_clk_o)
    else $error("peer clock high phase wrong");
  a_peer_low_len: assert property ($fell(peer_clk_o) |-> !peer_clk_o[*4])
    else $error("peer clock low phase short");
  a_dev_dat_hold: assert property (dev_clk_oe && dev_clk_o |-> $stable(dev_dat_o))
    else $error("device data moved while clock high");
  a_peer_dat_hold: assert property (peer_clk_o |-> $stable(peer_dat_o))
    else $error("peer data moved while clock high");
  a_no_collide: assert property (dev_dat_oe && peer_dat_oe |-> dev_dat_o == peer_dat_o)
    else $error("both ends drive different levels");
  a_clk_off_low: assert property ($fell(dev_clk_oe) |-> !$past(dev_clk_o))
    else $error("clock released while high");
endmodule
`default_nettype wire

/* File: sync_serial_bitrate_faults_tb_top.sv */
// Testbench joining channel and peer over one link.
// Assumes peer reload 3; device reload 3 except in the bitrate fault case.
`timescale 1ns/10ps
`default_nettype none
module sync_serial_bitrate_faults_tb_top;
  logic CLK, ARST_N, WR, RD, START, DRIVE, TX_IRQ, RX_IRQ, ERR_IRQ, BUSY, DONE;
  logic [1:0] ADDR;
  logic [4:0] WIDTH;
  logic [15:0] WDATA, RDATA, TX_DATA, RX_DATA, d, d2, s, b, cap;
  int failures = 0, n_compared = 0, n_rx = 0, n_tx = 0, n_dn = 0, last = 0, cyc = 0, maxsp = 0;
  int seed = 32'h3A56, k;
  int wl [3] = '{2, 8, 16};
  localparam logic [11:0] B_EN = 12'h1 << ssb_pkg::CB_EN, B_MS = 12'h1 << ssb_pkg::CB_MASTER;
  localparam logic [11:0] B_DR = 12'h1 << ssb_pkg::CB_DRIVE, B_AR = 12'h1 << ssb_pkg::CB_AREINIT;
  localparam logic [11:0] B_IO = 12'h1 << (ssb_pkg::CB_IEN_LO + 1);
  ssb_link_if lnk ();
  ssb_channel ssb_channel_i (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .TX_IRQ(TX_IRQ), .RX_IRQ(RX_IRQ), .ERR_IRQ(ERR_IRQ), .LNK(lnk.dev));
  ssb_peer ssb_peer_i (.CLK(CLK), .ARST_N(ARST_N), .RELOAD(16'h0003), .WIDTH(WIDTH),
    .START(START), .TX_DATA(TX_DATA), .DRIVE(DRIVE), .OPEN_DRAIN(1'b0), .BUSY(BUSY),
    .DONE(DONE), .RX_DATA(RX_DATA), .LNK(lnk.peer));
  ssb_link_checker ssb_link_checker_i (.CLK(CLK), .ARST_N(ARST_N), .dev_clk_o(lnk.dev_clk_o),
    .dev_clk_oe(lnk.dev_clk_oe), .dev_dat_o(lnk.dev_dat_o), .dev_dat_oe(lnk.dev_dat_oe),
    .peer_clk_o(lnk.peer_clk_o), .peer_clk_oe(lnk.peer_clk_oe), .peer_dat_o(lnk.peer_dat_o),
    .peer_dat_oe(lnk.peer_dat_oe), .clk_line(lnk.clk_line), .dat_line(lnk.dat_line));
  // ****************************************************************
  // Clock, monitors and helpers
  // ****************************************************************
  initial begin
    CLK = 0;
    forever #12.5 CLK = ~CLK;
  end
  // Pulse counters, wire capture at shift clock rises, rise spacing
  always @(posedge CLK) begin
    cyc++;
    if (RX_IRQ === 1'b1) n_rx++;
    if (TX_IRQ === 1'b1) n_tx++;
    if (DONE === 1'b1) n_dn++;
    if (lnk.clk_line === 1'b1 && b[0] === 1'b0) begin
      cap = {cap[14:0], lnk.dat_line};
      if (cyc - last < 17 && cyc - last > maxsp) maxsp = cyc - last;
      last = cyc;
    end
    b[0] = lnk.clk_line;
  end
  function automatic logic [15:0] msk(input logic [15:0] v, input int w);
    return v & 16'((17'h1 << w) - 17'h1);
  endfunction
  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk16(n, {15'h0, e}, {15'h0, g});
  endtask
  task automatic wt(ref int c, input int n);
    repeat (600) if (c < n) @(posedge CLK);
    chk16("event count", 16'(n), 16'(c));
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask
  task automatic cfg(input int w, input logic [11:0] bits);
    wr(ssb_pkg::REG_CTRL, {4'(w - 1), 12'h000});
    wr(ssb_pkg::REG_CTRL, {4'(w - 1), bits});
  endtask
  task automatic pstart(input logic [15:0] v);
    k = n_dn;
    @(posedge CLK);
    START <= 1'b1;
    TX_DATA <= v;
    @(posedge CLK);
    START <= 1'b0;
    wt(n_dn, k + 1);
    repeat (6) @(posedge CLK);
  endtask
  task automatic finish_test;
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    {ARST_N, WR, RD, START, DRIVE, ADDR, WDATA, TX_DATA, cap, b} = '0;
    WIDTH = 5'd16;
    repeat (20) @(posedge CLK);
    ARST_N <= 1'b1;
    rd(ssb_pkg::REG_CTRL, s); chk16("ctrl reset", ssb_pkg::CTRL_RST, s);
    rd(ssb_pkg::REG_BRT, s); chk16("reload reset", ssb_pkg::BRT_RST, s);
    d = 16'($random(seed));
    wr(ssb_pkg::REG_BRT, d); rd(ssb_pkg::REG_BRT, s); chk16("reload", d, s);
    wr(ssb_pkg::REG_BRT, 16'h0003);
    // Master half-duplex frames with echo
    foreach (wl[i]) begin
      k = n_rx;
      d = 16'($random(seed));
      cfg(wl[i], B_EN | B_MS | B_DR);
      wr(ssb_pkg::REG_BUF, d);
      wt(n_rx, k + 1);
      chk16("wire word", msk(d, wl[i]), msk(cap, wl[i]));
      rd(ssb_pkg::REG_BUF, s); chk16("echo", msk(d, wl[i]), msk(s, wl[i]));
      rd(ssb_pkg::REG_STAT, s); chk1("echo flag", 1'b0, s[ssb_pkg::SB_ECHO]);
    end
    rd(ssb_pkg::REG_BRT, d2); rd(ssb_pkg::REG_BRT, s);
    chk1("live range", 1'b1, d2 <= 16'h0003);
    chk16("live count", (d2 + 16'h2) & 16'h3, s);
    wr(ssb_pkg::REG_BRT, 16'h0009);
    // Back-to-back frames with overrun
    cfg(8, B_EN | B_MS | B_DR | B_IO);
    d = 16'($random(seed)); d2 = 16'($random(seed));
    maxsp = 0; k = n_rx;
    wr(ssb_pkg::REG_BUF, d); wt(n_tx, n_tx + 1); wr(ssb_pkg::REG_BUF, d2); wt(n_rx, k + 2);
    chk16("rise spacing", 16'h0008, 16'(maxsp));
    chk16("joined word", {d[7:0], d2[7:0]}, cap);
    rd(ssb_pkg::REG_STAT, s); chk1("overrun", 1'b1, s[ssb_pkg::SB_RXO]);
    chk1("fault line", 1'b1, ERR_IRQ);
    rd(ssb_pkg::REG_BUF, s); chk16("overwritten", d2 & 16'h00FF, s & 16'h00FF);
    rd(ssb_pkg::REG_STAT, s); chk1("sticky", 1'b1, s[ssb_pkg::SB_RXO]);
    wr(ssb_pkg::REG_STAT, 16'h000F); rd(ssb_pkg::REG_STAT, s);
    chk1("cleared", 1'b0, s[ssb_pkg::SB_RXO]);
    chk1("line off", 1'b0, ERR_IRQ);
    // Slave receive with stale buffer, then slave transmit
    wr(ssb_pkg::REG_CTRL, 16'hF000);
    rd(ssb_pkg::REG_BRT, s); chk16("write refused", 16'h0003, s);
    cfg(16, B_EN);
    d = 16'($random(seed)); DRIVE <= 1'b1; pstart(d);
    rd(ssb_pkg::REG_BUF, s); chk16("slave rx", d, s);
    rd(ssb_pkg::REG_STAT, s); chk1("underrun", 1'b1, s[ssb_pkg::SB_TXU]);
    chk1("no rate fault", 1'b0, s[ssb_pkg::SB_BRT]);
    DRIVE <= 1'b0; cfg(16, B_EN | B_DR); wr(ssb_pkg::REG_STAT, 16'h000F);
    // slave buffer loaded before the transfer
    d = 16'($random(seed)); wr(ssb_pkg::REG_BUF, d); pstart(16'($random(seed)));
    chk16("slave tx", d, RX_DATA);
    rd(ssb_pkg::REG_STAT, s); chk1("no underrun", 1'b0, s[ssb_pkg::SB_TXU]);
    // Slave at a slower programmed rate sees a bitrate fault
    cfg(16, 12'h000); wr(ssb_pkg::REG_BRT, 16'h000F); cfg(16, B_EN | B_AR);
    wr(ssb_pkg::REG_STAT, 16'h000F); DRIVE <= 1'b1; pstart(16'($random(seed)));
    rd(ssb_pkg::REG_STAT, s); chk1("rate fault", 1'b1, s[ssb_pkg::SB_BRT]);
    chk1("reinit idle", 1'b0, s[ssb_pkg::SB_BUSY]);
    chk1("masked line", 1'b0, ERR_IRQ);
    finish_test;
  end
  // Watchdog against a hung wait
  initial begin
    #750000;
    failures++;
    finish_test;
  end
endmodule
`default_nettype wire
